// >>> src/asd_pkg.sv
package asd_pkg;
   // digitised strap word: millivolts, one lsb per mV
   localparam int STRAP_W = 12;
   localparam int CODE_W  = 3;
   localparam int AXIS_W  = 9;
   localparam int ALIAS_W = 16;
   localparam int NUM_STRAPS = 3;
   localparam int NUM_EDGES  = 7;

   // upper band edges in mV; a level at or above an edge moves up one code
   localparam logic [STRAP_W-1:0] BIN_EDGE [NUM_EDGES] = '{
      12'h212,   // 530 mV
      12'h582,   // 1410 mV
      12'h7da,   // 2010 mV
      12'h97e,   // 2430 mV
      12'habe,   // 2750 mV
      12'hbc2,   // 3010 mV
      12'hc94    // 3220 mV
   };

   localparam logic [CODE_W-1:0] CODE_OPEN   = 3'h0;
   localparam logic [AXIS_W-1:0] AXIS_OPEN   = 9'h0ff;
   localparam logic [AXIS_W-1:0] AXIS_RST    = 9'h000;
   localparam logic [ALIAS_W-1:0] ALIAS_RST  = 16'h0000;
   localparam logic [ALIAS_W-1:0] ALIAS_ZERO = 16'h0000;
   localparam int HIGH_USED_BITS = 2;

   // settle time after reset before the straps are taken
   localparam int SYS_CLK_MHZ   = 250;
   localparam int SETTLE_NS     = 1000;
   localparam int SETTLE_CYCLES = (SETTLE_NS * SYS_CLK_MHZ) / 1000;

   // register map, byte addresses
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_AXIS   = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_ALIAS  = 8'h08;
   localparam int STAT_VALID = 0;
   localparam int STAT_OPEN  = 1;

   typedef enum logic [1:0] {ST_SETTLE, ST_SAMPLE, ST_HOLD} asd_state_t;
endpackage : asd_pkg

// >>> src/asd_strap_binner.sv
`timescale 1ns/10ps
// bins one digitised strap level into its 3-bit code
module asd_strap_binner #(
   parameter int STRAP_W = asd_pkg::STRAP_W
) (
   input  wire logic [STRAP_W-1:0]          level,
   output logic      [asd_pkg::CODE_W-1:0]  code
);
   // count the band edges at or below the level
   always_comb begin
      code = asd_pkg::CODE_OPEN;
      for (int i = 0; i < asd_pkg::NUM_EDGES; i++) begin
         if (level >= asd_pkg::BIN_EDGE[i]) begin
            code = code + 3'h1;
         end
      end
   end
endmodule : asd_strap_binner

// >>> src/asd_axis_strap_decoder.sv
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module asd_axis_strap_decoder #(
   parameter int SETTLE_CYCLES = asd_pkg::SETTLE_CYCLES
) (
   input  wire logic                          sys_clk,
   input  wire logic                          rst,
   input  wire logic [asd_pkg::STRAP_W-1:0]   axisStrapLow,
   input  wire logic [asd_pkg::STRAP_W-1:0]   axisStrapMid,
   input  wire logic [asd_pkg::STRAP_W-1:0]   axisStrapHigh,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [asd_pkg::ADDR_W-1:0]    paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   output logic      [asd_pkg::AXIS_W-1:0]    axisNumber,
   output logic      [asd_pkg::ALIAS_W-1:0]   stationAlias,
   output logic                               axisValid
);
   localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
   localparam int SW    = asd_pkg::STRAP_W;
   localparam int CW    = asd_pkg::CODE_W;

   asd_pkg::asd_state_t state;
   logic [CNT_W-1:0]    settleCnt;
   logic [SW-1:0]       strapMeta [asd_pkg::NUM_STRAPS];
   logic [SW-1:0]       strapSync [asd_pkg::NUM_STRAPS];
   logic [SW-1:0]       strapPin  [asd_pkg::NUM_STRAPS];
   logic [CW-1:0]       strapCode [asd_pkg::NUM_STRAPS];
   logic                allOpen;
   logic                strapsOpen;
   logic [asd_pkg::AXIS_W-1:0] next_axis;
   logic                apbAccess;
   logic                apbDone;
   logic                mapped;

   assign strapPin[0] = axisStrapLow;
   assign strapPin[1] = axisStrapMid;
   assign strapPin[2] = axisStrapHigh;

   // two-flop synchronisers and binners, one per strap
   for (genvar g = 0; g < asd_pkg::NUM_STRAPS; g++) begin : g_strap
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            strapMeta[g] <= '0;
            strapSync[g] <= '0;
         end else begin
            strapMeta[g] <= strapPin[g];
            strapSync[g] <= strapMeta[g];
         end
      end

      asd_strap_binner #(
         .STRAP_W (SW)
      ) u_binner (
         .level (strapSync[g]),
         .code  (strapCode[g])
      );
   end

   // open or grounded straps all land in the lowest band
   assign allOpen = (strapCode[0] == asd_pkg::CODE_OPEN) &&
                    (strapCode[1] == asd_pkg::CODE_OPEN) &&
                    (strapCode[2] == asd_pkg::CODE_OPEN);

   // weighted sum 64*high + 8*mid + low, high code top bit dropped
   always_comb begin
      if (allOpen) begin
         next_axis = asd_pkg::AXIS_OPEN;
      end else begin
         next_axis = {1'b0, strapCode[2][asd_pkg::HIGH_USED_BITS-1:0],
                      strapCode[1], strapCode[0]};
      end
   end

   // settle after reset, take the straps once, then hold
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state     <= asd_pkg::ST_SETTLE;
         settleCnt <= '0;
      end else begin
         unique case (state)
            asd_pkg::ST_SETTLE: begin
               if (settleCnt == CNT_W'(SETTLE_CYCLES - 1)) begin
                  state <= asd_pkg::ST_SAMPLE;
               end else begin
                  settleCnt <= settleCnt + 1'b1;
               end
            end
            asd_pkg::ST_SAMPLE: begin
               state <= asd_pkg::ST_HOLD;
            end
            asd_pkg::ST_HOLD: begin
               state <= asd_pkg::ST_HOLD;
            end
         endcase
      end
   end

   // axis number and open flag latched in the sample cycle only
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         axisNumber <= asd_pkg::AXIS_RST;
         strapsOpen <= 1'b0;
         axisValid  <= 1'b0;
      end else if (state == asd_pkg::ST_SAMPLE) begin
         axisNumber <= next_axis;
         strapsOpen <= allOpen;
         axisValid  <= 1'b1;
      end
   end

   // apb: one wait state, pready high in the second access cycle
   assign apbAccess = psel && penable;
   assign apbDone   = apbAccess && pready;
   assign mapped    = (paddr == asd_pkg::REG_AXIS) ||
                      (paddr == asd_pkg::REG_STATUS) ||
                      (paddr == asd_pkg::REG_ALIAS);

   // station alias: software sets it, open straps force it to zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stationAlias <= asd_pkg::ALIAS_RST;
      end else if ((state == asd_pkg::ST_SAMPLE && allOpen) ||
                   strapsOpen) begin
         stationAlias <= asd_pkg::ALIAS_ZERO;
      end else if (apbDone && pwrite && paddr == asd_pkg::REG_ALIAS) begin
         stationAlias <= pwdata[asd_pkg::ALIAS_W-1:0];
      end
   end

   // bus answer and read data
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= apbAccess && !pready;
         pslverr <= apbAccess && !pready && !mapped;
         prdata  <= '0;
         if (apbAccess && !pready && !pwrite) begin
            if (paddr == asd_pkg::REG_AXIS) begin
               prdata[asd_pkg::AXIS_W-1:0] <= axisNumber;
            end else if (paddr == asd_pkg::REG_STATUS) begin
               prdata[asd_pkg::STAT_VALID] <= axisValid;
               prdata[asd_pkg::STAT_OPEN]  <= strapsOpen;
            end else if (paddr == asd_pkg::REG_ALIAS) begin
               prdata[asd_pkg::ALIAS_W-1:0] <= stationAlias;
            end
         end
      end
   end

   // checks
   property p_code_low;
      @(posedge sys_clk) disable iff (rst)
      strapSync[0] < asd_pkg::BIN_EDGE[0] |-> strapCode[0] == 3'h0;
   endproperty
   a_code_low: assert property (p_code_low)
      else $error("low band level not coded 000");

   property p_code_top;
      @(posedge sys_clk) disable iff (rst)
      strapSync[2] >= asd_pkg::BIN_EDGE[6] |-> strapCode[2] == 3'h7;
   endproperty
   a_code_top: assert property (p_code_top)
      else $error("top band level not coded 111");

   property p_weighted;
      @(posedge sys_clk) disable iff (rst)
      (state == asd_pkg::ST_SAMPLE && !allOpen) |=>
         axisNumber == 9'(($past(strapCode[2]) & 3'h3) * 64 +
                           $past(strapCode[1]) * 8 + $past(strapCode[0]));
   endproperty
   a_weighted: assert property (p_weighted)
      else $error("axis number not the weighted sum");

   property p_open_255;
      @(posedge sys_clk) disable iff (rst)
      (state == asd_pkg::ST_SAMPLE && allOpen) |=>
         axisNumber == 9'h0ff && axisValid;
   endproperty
   a_open_255: assert property (p_open_255)
      else $error("open straps did not give 255");

   sequence s_open_taken;
      state == asd_pkg::ST_SAMPLE && allOpen;
   endsequence
   property p_alias_zero;
      @(posedge sys_clk) disable iff (rst)
      s_open_taken |=> (stationAlias == 16'h0000) [*8];
   endproperty
   a_alias_zero: assert property (p_alias_zero)
      else $error("station alias not zero with open straps");

   property p_bit8;
      @(posedge sys_clk) disable iff (rst)
      axisValid |-> axisNumber[8] == 1'b0 || axisNumber == 9'h0ff;
   endproperty
   a_bit8: assert property (p_bit8)
      else $error("axis number bit 8 set");

   property p_hold;
      @(posedge sys_clk) disable iff (rst)
      axisValid |=> axisValid && $stable(axisNumber);
   endproperty
   a_hold: assert property (p_hold)
      else $error("axis number changed after sampling");

   property p_apb_ready;
      @(posedge sys_clk) disable iff (rst)
      (psel && penable && !pready) |=> pready ##1 !pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready)
      else $error("pready not a single cycle after one wait");
endmodule : asd_axis_strap_decoder

// >>> testbench/asd_strap_board.sv
`timescale 1ns/10ps
// board straps: turns a wanted code per strap into a millivolt level
module asd_strap_board (
   input  wire logic [8:0]  selCode,
   input  wire logic [1:0]  pos,
   input  wire logic [11:0] jitter,
   output logic      [11:0] axisStrapLow,
   output logic      [11:0] axisStrapMid,
   output logic      [11:0] axisStrapHigh
);
   // band floors in mV, last entry is the supply ceiling
   localparam logic [11:0] BOT [9] = '{12'h000, 12'h212, 12'h582, 12'h7da,
      12'h97e, 12'habe, 12'hbc2, 12'hc94, 12'hce4};

   // pos picks band floor, band top or a point inside
   function automatic logic [11:0] lvl(input logic [2:0]  c,
                                       input logic [1:0]  p,
                                       input logic [11:0] j);
      logic [11:0] lo;
      logic [11:0] hi;
      lo = BOT[c];
      hi = BOT[int'(c) + 1];
      case (p)
         2'h0: return lo;
         2'h1: return hi - 12'h001;
         default: return lo + (j % (hi - lo));
      endcase
   endfunction : lvl

   // resistor dividers settle to a steady level
   always_comb begin
      axisStrapLow  = lvl(selCode[2:0], pos, jitter);
      axisStrapMid  = lvl(selCode[5:3], pos, jitter);
      axisStrapHigh = lvl(selCode[8:6], pos, jitter);
   end
endmodule : asd_strap_board

// >>> testbench/tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin nErrors++; \
   $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb;
   localparam int SC = 2;
   logic        sys_clk = 1'b0;
   logic        rst     = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [8:0]  selCode = 9'h000;
   logic [1:0]  pos     = 2'h0;
   logic [11:0] jitter  = 12'h000;
   logic [11:0] lvLow, lvMid, lvHigh;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, axisValid, err;
   logic [8:0]  axisNumber;
   logic [15:0] stationAlias;
   logic [15:0] wantAlias;
   int          nErrors = 0;
   int          nChecks = 0;

   // 250 MHz clock
   always #2 sys_clk = ~sys_clk;

   asd_strap_board board (.selCode(selCode), .pos(pos), .jitter(jitter),
      .axisStrapLow(lvLow), .axisStrapMid(lvMid), .axisStrapHigh(lvHigh));
   asd_axis_strap_decoder #(.SETTLE_CYCLES(SC)) dut (.sys_clk(sys_clk),
      .rst(rst), .axisStrapLow(lvLow), .axisStrapMid(lvMid),
      .axisStrapHigh(lvHigh), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .axisNumber(axisNumber),
      .stationAlias(stationAlias), .axisValid(axisValid));

   // expected axis number from {high, mid, low} codes
   function automatic logic [8:0] expAxis(input logic [8:0] c);
      if (c == 9'h000) return 9'h0ff;
      return {1'b0, c[7:6], c[5:3], c[2:0]};
   endfunction : expAxis

   // one apb transfer, held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] r,
                      output logic e);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      // pready seen high at an edge ends this wait; the watchdog ends a hung one
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic printVerdict();
      $display("checks %0d errors %0d", nChecks, nErrors);
      if (nErrors == 0 && nChecks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : printVerdict

   // watchdog against a hung handshake
   initial begin
      repeat (5000) @(posedge sys_clk);
      nErrors++;
      printVerdict();
   end

   // each pass: reset with new straps, check decode, registers and hold
   initial begin
      logic [8:0] c;
      logic       open;
      void'($urandom(46399));
      for (int it = 0; it < 16; it++) begin
         c = (it < 8) ? {3{it[2:0]}} : (it == 8) ? 9'h100 : 9'($urandom);
         open = (c == 9'h000);
         @(posedge sys_clk);
         rst <= 1'b1;
         selCode <= c;
         pos <= 2'($urandom);
         jitter <= 12'($urandom);
         repeat (6) @(posedge sys_clk);
         rst <= 1'b0;
         // first edge after release still shows the reset values
         @(posedge sys_clk);
         #1 `CHK(axisValid, 1'b0)
         `CHK(axisNumber, 9'h000)
         `CHK(stationAlias, 16'h0000)
         // straps are taken at edge SC+1 after release
         repeat (SC - 1) @(posedge sys_clk);
         #1 `CHK(axisValid, 1'b0)
         @(posedge sys_clk);
         #1 `CHK(axisValid, 1'b1)
         `CHK(axisNumber, expAxis(c))
         apb(1'b0, 8'h04, 32'h0, rd, err);
         `CHK(rd, ({30'h0, open, 1'b1}))
         `CHK(err, 1'b0)
         wantAlias = 16'($urandom);
         apb(1'b1, 8'h08, {16'hffff, wantAlias}, rd, err);
         apb(1'b0, 8'h08, 32'h0, rd, err);
         `CHK(rd, ({16'h0, open ? 16'h0000 : wantAlias}))
         `CHK(stationAlias, (open ? 16'h0000 : wantAlias))
         apb(1'b0, 8'h0c, 32'h0, rd, err);
         `CHK(err, 1'b1)
         `CHK(rd, 32'h0)
         selCode <= ~c;
         apb(1'b1, 8'h00, 32'h1ff, rd, err);
         apb(1'b0, 8'h00, 32'h0, rd, err);
         `CHK(rd, ({23'h0, expAxis(c)}))
         `CHK(axisNumber, expAxis(c))
      end
      printVerdict();
   end
endmodule : tb
